// [remote_serial_peer.sv]
`timescale 1ns/1ps
`default_nettype none
module remote_serial_peer
    import uart_efc_pkg::*;
(
    // Serial lines
    input  wire logic txLine,
    output logic      rxLine,
    // Clock
    input  wire logic clk
);
    logic [7:0] gotByte;
    int         gotCount;

    // =========================
    // Sender, 8N1 LSB first
    // line idles high
    initial begin
        rxLine = 1'b1;
        gotByte = ZERO_BYTE;
        gotCount = 0;
    end

    task automatic send_byte(input logic [7:0] b);
        logic [9:0] frame;
        frame = {1'b1, b, 1'b0};
        for (int i = 0; i < FRAME_BITS; i++) begin
            rxLine <= frame[i];
            repeat (BIT_CYCLES) @(posedge clk);
        end
    endtask : send_byte

    // =========================
    // Receiver, samples mid-bit
    always begin
        @(posedge clk);
        if (txLine === 1'b0) begin
            repeat (BIT_CYCLES / 2) @(posedge clk);
            for (int i = 0; i < 8; i++) begin
                repeat (BIT_CYCLES) @(posedge clk);
                gotByte[i] = txLine;
            end
            repeat (BIT_CYCLES) @(posedge clk);
            gotCount++;
        end
    end
endmodule : remote_serial_peer
`default_nettype wire

// [uart_efc_pkg.sv]
package uart_efc_pkg;

    // ==========================================
    // Register indices (byte address = 4 * index)
    localparam logic [3:0] REG_TXRX_CONTROL   = 4'h0;
    localparam logic [3:0] REG_SCRATCH_BYTE   = 4'h1;
    localparam logic [3:0] REG_FEATURE_CTRL   = 4'h2;
    localparam logic [3:0] REG_ENHANCED_FEAT  = 4'h3;
    localparam logic [3:0] REG_MODEM_CONTROL  = 4'h4;
    localparam logic [3:0] REG_STOP_CHAR_2    = 4'h5;
    localparam logic [3:0] REG_STATUS         = 4'h6;
    localparam logic [3:0] REG_RX_DATA        = 4'h7;
    localparam logic [3:0] REG_TX_DATA        = 4'h8;
    localparam logic [3:0] REG_RX_LEVEL       = 4'h9;

    // ==========================================
    // Field positions
    localparam int TXDIS_BIT    = 3;
    localparam int RXDIS_BIT    = 2;
    localparam int NINEBIT_BIT  = 0;
    localparam int DLY_LSB      = 4;
    localparam int HDX_BIT      = 5;
    localparam int IRINV_BIT    = 4;
    localparam int AUTOCTS_BIT  = 7;
    localparam int AUTORTS_BIT  = 6;
    localparam int SPECIAL_BIT  = 5;
    localparam int ENH_BIT      = 4;
    localparam int MCR_SEL_BIT  = 2;
    localparam int MCR_SCI_BIT  = 3;

    // ==========================================
    // Reset values and masks
    localparam logic [7:0] SCRATCH_RESET = 8'hff;
    localparam logic [7:0] ZERO_BYTE     = 8'h00;
    localparam logic [7:0] TXRX_ENH_MASK = 8'hfc;
    localparam logic [7:0] MCR_ENH_MASK  = 8'hec;
    localparam logic [1:0] SEL_FIRST     = 2'b10;
    localparam logic [1:0] SEL_SECOND    = 2'b01;

    // ==========================================
    // Timing
    localparam int CLK_MHZ       = 100;
    localparam int BIT_NS        = 1000;
    localparam int BIT_CYCLES    = BIT_NS * CLK_MHZ / 1000;
    localparam int FRAME_BITS    = 10;
    localparam int UPPER_TRIGGER = 12;
    localparam int LOWER_TRIGGER = 4;

    typedef enum logic [1:0] {
        TX_IDLE  = 2'b00,
        TX_SHIFT = 2'b01,
        TX_TURN  = 2'b10
    } tx_state_t;

    typedef struct packed {
        logic [7:0] txrxControl;
        logic [7:0] scratchByte;
        logic [7:0] featureControl;
        logic [7:0] enhancedFeature;
        logic [7:0] modemControl;
        logic [7:0] stopChar2;
        logic       ack;
        logic [7:0] rdata;
    } regs_t;

endpackage : uart_efc_pkg

// [uart_enhanced_feature_control.sv]
// Implementation choices: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module uart_enhanced_feature_control
    import uart_efc_pkg::*;
#(
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [5:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // Serial pins
    input  wire logic        rxPin,
    input  wire logic        ctsPin_n,
    input  wire logic        dsrPin_n,
    output logic             txPin,
    output logic             rtsPin_n,
    output logic             dtrPin_n,
    // Status outputs
    output logic             txInterrupt,
    output logic             rxTrigger,
    output logic             specialChar,
    output logic             stopCharSeen,
    output logic             nineBitMode
);

    // ==========================================
    // Reset and input synchronisers
    logic [1:0] rstSync;
    logic       rstL;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) rstSync <= 2'b00;
        else        rstSync <= {rstSync[0], 1'b1};
    end
    assign rstL = rstSync[1];

    logic [2:0] inMeta;
    logic [2:0] inSync;
    always_ff @(posedge clk or negedge rstL) begin
        if (!rstL) begin
            inMeta <= 3'b111;
            inSync <= 3'b111;
        end else begin
            inMeta <= {rxPin, ctsPin_n, dsrPin_n};
            inSync <= inMeta;
        end
    end

    // ==========================================
    // Register file
    regs_t r;
    regs_t next_r;
    logic       wrStb;
    logic       rdStb;
    logic [3:0] regIdx;
    logic       enh;
    assign regIdx = adr_i[5:2];
    assign wrStb  = cyc_i && stb_i && we_i && !r.ack && sel_i[0];
    assign rdStb  = cyc_i && stb_i && !we_i && !r.ack;
    assign enh    = r.enhancedFeature[ENH_BIT];

    // Receive queue state
    logic [7:0] rxMem [DEPTH];
    logic [$clog2(DEPTH):0]   rxCount;
    logic [$clog2(DEPTH)-1:0] rxWp;
    logic [$clog2(DEPTH)-1:0] rxRp;
    logic       rxPush;
    logic [7:0] rxChar;
    logic       rxPop;
    assign rxPop = rdStb && regIdx == REG_RX_DATA && rxCount != '0;

    // Transmit state
    logic [7:0] txHold;
    logic       txHoldFull;
    tx_state_t  txState;
    logic [15:0] txCnt;
    logic [3:0]  txBits;
    logic [9:0]  txShift;
    logic [3:0]  turnBits;
    logic        dirHigh;
    logic        ovrRts;
    logic        sticky;
    logic        stopFlag;

    always_comb begin
        next_r     = r;
        next_r.ack = cyc_i && stb_i && !r.ack;
        if (wrStb) begin
            case (regIdx)
                REG_TXRX_CONTROL: next_r.txrxControl = enh ? dat_i[7:0]
                    : (r.txrxControl & TXRX_ENH_MASK) | (dat_i[7:0] & ~TXRX_ENH_MASK);
                REG_SCRATCH_BYTE: next_r.scratchByte = dat_i[7:0];
                REG_FEATURE_CTRL: next_r.featureControl = dat_i[7:0] & 8'h30;
                REG_ENHANCED_FEAT: next_r.enhancedFeature = dat_i[7:0];
                REG_MODEM_CONTROL: next_r.modemControl = enh ? dat_i[7:0]
                    : (r.modemControl & MCR_ENH_MASK) | (dat_i[7:0] & ~MCR_ENH_MASK);
                REG_STOP_CHAR_2: next_r.stopChar2 = dat_i[7:0];
                default: ;
            endcase
        end
        next_r.rdata = ZERO_BYTE;
        case (regIdx)
            REG_SCRATCH_BYTE:  next_r.rdata = r.scratchByte;
            REG_FEATURE_CTRL:  next_r.rdata = r.featureControl;
            REG_ENHANCED_FEAT: next_r.rdata = r.enhancedFeature;
            REG_MODEM_CONTROL: next_r.rdata = r.modemControl;
            REG_STATUS: next_r.rdata = {3'b000, stopFlag, sticky, txHoldFull,
                                        txState != TX_IDLE, rxCount != '0};
            REG_RX_DATA:  next_r.rdata = rxCount != '0 ? rxMem[rxRp] : ZERO_BYTE;
            REG_RX_LEVEL: next_r.rdata = 8'(rxCount);
            default: next_r.rdata = ZERO_BYTE;
        endcase
    end

    always_ff @(posedge clk or negedge rstL) begin
        if (!rstL) begin
            r <= '{txrxControl: ZERO_BYTE, scratchByte: SCRATCH_RESET,
                   featureControl: ZERO_BYTE, enhancedFeature: ZERO_BYTE,
                   modemControl: ZERO_BYTE, stopChar2: ZERO_BYTE,
                   ack: 1'b0, rdata: ZERO_BYTE};
        end else begin
            r <= next_r;
        end
    end
    assign ack_o = r.ack;
    assign dat_o = {24'h000000, r.rdata};
    assign nineBitMode = r.txrxControl[NINEBIT_BIT];

    // ==========================================
    // Transmitter
    logic txLoad;
    logic ctsStop;
    logic txDone;
    assign txLoad = wrStb && regIdx == REG_TX_DATA;
    assign ctsStop = r.enhancedFeature[AUTOCTS_BIT] &&
                     (r.modemControl[MCR_SEL_BIT] ? inSync[0] : inSync[1]);
    assign txDone = txState == TX_SHIFT && txBits == 4'(FRAME_BITS - 1)
                    && txCnt == 16'(BIT_CYCLES - 1);

    always_ff @(posedge clk or negedge rstL) begin
        if (!rstL) begin
            txHold     <= ZERO_BYTE;
            txHoldFull <= 1'b0;
            txState    <= TX_IDLE;
            txCnt      <= 16'h0000;
            txBits     <= 4'h0;
            txShift    <= 10'h3ff;
            turnBits   <= 4'h0;
            dirHigh    <= 1'b0;
        end else begin
            if (txLoad) begin
                txHold     <= dat_i[7:0];
                txHoldFull <= 1'b1;
                dirHigh    <= 1'b1;
            end
            txCnt <= (txCnt == 16'(BIT_CYCLES - 1)) ? 16'h0000 : txCnt + 16'h0001;
            case (txState)
                TX_IDLE: begin
                    txCnt <= 16'h0000;
                    if (txHoldFull && !txLoad && !r.txrxControl[TXDIS_BIT] && !ctsStop) begin
                        txShift    <= {1'b1, txHold, 1'b0};
                        txHoldFull <= 1'b0;
                        txBits     <= 4'h0;
                        txState    <= TX_SHIFT;
                    end
                end
                TX_SHIFT: begin
                    if (txCnt == 16'(BIT_CYCLES - 1)) begin
                        txShift <= {1'b1, txShift[9:1]};
                        txBits  <= txBits + 4'h1;
                    end
                    if (txDone) begin
                        turnBits <= r.txrxControl[7:DLY_LSB];
                        txState  <= (txHoldFull || txLoad) ? TX_IDLE : TX_TURN;
                    end
                end
                TX_TURN: begin
                    if (txHoldFull || txLoad) begin
                        txState <= TX_IDLE;
                    end else if (turnBits == 4'h0) begin
                        dirHigh <= 1'b0;
                        txState <= TX_IDLE;
                    end else if (txCnt == 16'(BIT_CYCLES - 1)) begin
                        turnBits <= turnBits - 4'h1;
                    end
                end
                default: txState <= TX_IDLE;
            endcase
        end
    end
    assign txPin = txState == TX_SHIFT ? txShift[0] : 1'b1;
    assign txInterrupt = r.featureControl[HDX_BIT]
                         ? (!txHoldFull && txState != TX_SHIFT) : !txHoldFull;

    // ==========================================
    // Receiver
    logic       rxIn;
    logic [15:0] rxCnt;
    logic [3:0]  rxBits;
    logic [7:0]  rxSh;
    logic        rxBusy;
    logic        rxArmed;
    logic        rxDisPrev;
    logic        rxEnd;
    assign rxIn  = inSync[2] ^ r.featureControl[IRINV_BIT];
    assign rxEnd = rxBusy && rxBits == 4'(FRAME_BITS - 1) && rxCnt == 16'(BIT_CYCLES - 1);

    always_ff @(posedge clk or negedge rstL) begin
        if (!rstL) begin
            rxCnt     <= 16'h0000;
            rxBits    <= 4'h0;
            rxSh      <= ZERO_BYTE;
            rxBusy    <= 1'b0;
            rxArmed   <= 1'b1;
            rxDisPrev <= 1'b0;
        end else begin
            rxDisPrev <= r.txrxControl[RXDIS_BIT];
            if (r.txrxControl[RXDIS_BIT] && !rxDisPrev) rxArmed <= 1'b1;
            if (!r.txrxControl[RXDIS_BIT]) rxArmed <= 1'b1;
            if (!rxBusy) begin
                if (!rxIn && rxArmed) begin
                    rxBusy <= 1'b1;
                    rxCnt  <= 16'(BIT_CYCLES / 2);
                    rxBits <= 4'h0;
                end
            end else begin
                rxCnt <= (rxCnt == 16'(BIT_CYCLES - 1)) ? 16'h0000 : rxCnt + 16'h0001;
                if (rxCnt == 16'(BIT_CYCLES - 1)) begin
                    rxBits <= rxBits + 4'h1;
                    if (rxBits != 4'h0 && rxBits != 4'(FRAME_BITS - 1))
                        rxSh <= {rxIn, rxSh[7:1]};
                end
                if (rxEnd) begin
                    rxBusy <= 1'b0;
                    if (r.txrxControl[RXDIS_BIT]) rxArmed <= 1'b0;
                end
            end
        end
    end

    // ==========================================
    // Character compare and receive queue
    logic match2;
    logic swallow;
    assign rxChar = rxSh;
    assign match2  = r.enhancedFeature[SPECIAL_BIT] && rxChar == r.stopChar2;
    assign swallow = match2 && r.enhancedFeature[1:0] == SEL_SECOND;
    assign rxPush  = rxEnd && !swallow && rxCount != ($clog2(DEPTH)+1)'(DEPTH);

    always_ff @(posedge clk) begin
        if (rxPush) rxMem[rxWp] <= rxChar;
    end

    always_ff @(posedge clk or negedge rstL) begin
        if (!rstL) begin
            rxWp     <= '0;
            rxRp     <= '0;
            rxCount  <= '0;
            sticky   <= 1'b0;
            stopFlag <= 1'b0;
            ovrRts   <= 1'b0;
        end else begin
            if (rxPush) rxWp <= rxWp + 1'b1;
            if (rxPop)  rxRp <= rxRp + 1'b1;
            rxCount <= rxCount + (rxPush ? 1'b1 : 1'b0) - (rxPop ? 1'b1 : 1'b0);
            // Set wins over a status read clear
            if (rdStb && regIdx == REG_STATUS) begin
                sticky   <= 1'b0;
                stopFlag <= 1'b0;
            end
            if (rxEnd && match2) sticky <= 1'b1;
            if (rxEnd && swallow) stopFlag <= 1'b1;
            if (rxCount >= ($clog2(DEPTH)+1)'(UPPER_TRIGGER)) ovrRts <= 1'b1;
            else if (rxCount < ($clog2(DEPTH)+1)'(LOWER_TRIGGER)) ovrRts <= 1'b0;
        end
    end
    assign specialChar  = sticky;
    assign stopCharSeen = stopFlag;
    assign rxTrigger    = r.enhancedFeature[AUTORTS_BIT] &&
                          rxCount >= ($clog2(DEPTH)+1)'(UPPER_TRIGGER);

    // ==========================================
    // Modem output pins
    logic autoHigh;
    assign autoHigh = r.enhancedFeature[AUTORTS_BIT] && ovrRts;
    assign rtsPin_n = r.featureControl[HDX_BIT] ? dirHigh
                      : (r.modemControl[MCR_SEL_BIT] ? !r.modemControl[1]
                                                     : (!r.modemControl[1] || autoHigh));
    assign dtrPin_n = r.modemControl[MCR_SEL_BIT] ? (!r.modemControl[0] || autoHigh)
                                                  : !r.modemControl[0];

    // ==========================================
    // Checks
    property p_txhalt;
        @(posedge clk) disable iff (!rstL)
        (txState == TX_IDLE && r.txrxControl[TXDIS_BIT]) |=> txState != TX_SHIFT;
    endproperty
    a_txhalt: assert property (p_txhalt) else $error("tx left idle while disabled");
    property p_scratch;
        @(posedge clk) disable iff (!rstL)
        (wrStb && regIdx == REG_SCRATCH_BYTE) |=> r.scratchByte == $past(dat_i[7:0]);
    endproperty
    a_scratch: assert property (p_scratch) else $error("scratch not stored");
    property p_txint;
        @(posedge clk) disable iff (!rstL)
        (!r.featureControl[HDX_BIT] && !txHoldFull) |-> txInterrupt;
    endproperty
    a_txint: assert property (p_txint) else $error("tx interrupt missing");
    property p_txint_hdx;
        @(posedge clk) disable iff (!rstL)
        (r.featureControl[HDX_BIT] && txState == TX_SHIFT) |-> !txInterrupt;
    endproperty
    a_txint_hdx: assert property (p_txint_hdx) else $error("interrupt while shifting");
    property p_dir;
        @(posedge clk) disable iff (!rstL)
        (r.featureControl[HDX_BIT] && txState == TX_SHIFT) |-> rtsPin_n;
    endproperty
    a_dir: assert property (p_dir) else $error("direction low while sending");
    property p_cts;
        @(posedge clk) disable iff (!rstL)
        (txState == TX_IDLE && ctsStop) |=> txState != TX_SHIFT;
    endproperty
    a_cts: assert property (p_cts) else $error("sent while flow stopped");
    property p_swallow;
        @(posedge clk) disable iff (!rstL)
        (rxEnd && swallow) |-> !rxPush ##1 stopFlag && sticky;
    endproperty
    a_swallow: assert property (p_swallow) else $error("second stop char stored");
    property p_guard;
        @(posedge clk) disable iff (!rstL)
        (wrStb && !enh && regIdx == REG_TXRX_CONTROL)
            |=> r.txrxControl[7:2] == $past(r.txrxControl[7:2]);
    endproperty
    a_guard: assert property (p_guard) else $error("guarded bits changed");
    property p_irinv;
        @(posedge clk) disable iff (!rstL)
        r.featureControl[IRINV_BIT] |-> rxIn == !inSync[2];
    endproperty
    a_irinv: assert property (p_irinv) else $error("ir polarity wrong");

    c_tx:   cover property (@(posedge clk) disable iff (!rstL) txDone);
    c_rx:   cover property (@(posedge clk) disable iff (!rstL) rxPush);
    c_spec: cover property (@(posedge clk) disable iff (!rstL) rxEnd && match2);
    c_turn: cover property (@(posedge clk) disable iff (!rstL) txState == TX_TURN);

endmodule : uart_enhanced_feature_control
`default_nettype wire

// [uart_enhanced_feature_control_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module uart_enhanced_feature_control_tb
    import uart_efc_pkg::*;
;
    logic        clk;
    logic        rst_n;
    logic        cyc;
    logic        stb;
    logic        we;
    logic [5:0]  adr;
    logic [31:0] wdat;
    logic [31:0] rdat;
    logic        ack;
    logic        rxLine;
    logic        ctsLine_n;
    logic        dsrLine_n;
    logic        dtrLine_n;
    logic        txLine;
    logic        rtsLine_n;
    logic        txIrq;
    logic        rxTrig;
    logic        special;
    logic        stopSeen;
    logic        nineBit;
    logic [7:0]  rd;
    int          mismatches;
    int          checked;
    int          cycles;
    int          sent;

    // =========================
    // Design and far side
    uart_enhanced_feature_control #(.DEPTH(16)) i_uart_enhanced_feature_control (
        .clk(clk), .rst_n(rst_n), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(4'hf), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
        .rxPin(rxLine), .ctsPin_n(ctsLine_n), .dsrPin_n(dsrLine_n), .txPin(txLine),
        .rtsPin_n(rtsLine_n), .dtrPin_n(dtrLine_n), .txInterrupt(txIrq), .rxTrigger(rxTrig),
        .specialChar(special), .stopCharSeen(stopSeen), .nineBitMode(nineBit));
    remote_serial_peer i_remote_serial_peer (
        .txLine(txLine), .rxLine(rxLine), .clk(clk));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // =========================
    // Tasks
    task automatic report_and_stop();
        $display("Checks %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : report_and_stop

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wb(input logic wr, input logic [3:0] idx, input logic [7:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= wr;
        adr <= {idx, 2'b00};
        wdat <= {24'h000000, d};
        // Only the hang guard ends a wait for the answer
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        rd = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb

    task automatic rdchk(input string what, input logic [3:0] idx, input logic [7:0] exp);
        wb(1'b0, idx, ZERO_BYTE);
        check(what, rd, exp);
    endtask : rdchk

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask : idle

    task automatic rx(input logic [7:0] b);
        i_remote_serial_peer.send_byte(b);
        idle(20);
    endtask : rx

    task automatic wait_tx(input logic [7:0] exp);
        int n;
        n = 0;
        while (i_remote_serial_peer.gotCount == sent && n < 3000) begin
            @(posedge clk);
            n++;
        end
        check("tx count", 8'(i_remote_serial_peer.gotCount), 8'(sent + 1));
        sent = i_remote_serial_peer.gotCount;
        check("tx byte", i_remote_serial_peer.gotByte, exp);
    endtask : wait_tx

    // Hang guard, sized well above the frame count
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            mismatches++;
            report_and_stop();
        end
    end

    // =========================
    // Sequence
    initial begin
        rst_n = 1'b0;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 6'h00;
        wdat = 32'h00000000;
        ctsLine_n = 1'b0;
        dsrLine_n = 1'b0;
        mismatches = 0;
        checked = 0;
        cycles = 0;
        sent = 0;
        idle(20);
        rst_n <= 1'b1;
        idle(4);
        rdchk("scratch rst", REG_SCRATCH_BYTE, SCRATCH_RESET);
        rdchk("feature rst", REG_FEATURE_CTRL, ZERO_BYTE);
        rdchk("enhanced rst", REG_ENHANCED_FEAT, ZERO_BYTE);
        rdchk("modem rst", REG_MODEM_CONTROL, ZERO_BYTE);
        wb(1'b1, REG_SCRATCH_BYTE, 8'h5a);
        rdchk("scratch rw", REG_SCRATCH_BYTE, 8'h5a);
        rdchk("unmapped", 4'hf, ZERO_BYTE);
        wb(1'b1, REG_MODEM_CONTROL, 8'h2c);
        rdchk("modem locked", REG_MODEM_CONTROL, ZERO_BYTE);
        wb(1'b1, REG_TXRX_CONTROL, 8'h09);
        check("unguarded bit", {7'h00, nineBit}, 8'h01);
        wb(1'b1, REG_ENHANCED_FEAT, 8'h10);
        wb(1'b1, REG_MODEM_CONTROL, 8'h20);
        wb(1'b1, REG_ENHANCED_FEAT, 8'h00);
        wb(1'b1, REG_MODEM_CONTROL, 8'h00);
        rdchk("modem latched", REG_MODEM_CONTROL, 8'h20);
        wb(1'b1, REG_ENHANCED_FEAT, 8'h10);
        wb(1'b1, REG_MODEM_CONTROL, 8'h00);
        wb(1'b1, REG_TXRX_CONTROL, 8'h01);
        check("nine bit", {7'h00, nineBit}, 8'h01);
        wb(1'b1, REG_TXRX_CONTROL, 8'h00);
        check("eight bit", {7'h00, nineBit}, 8'h00);
        wb(1'b1, REG_TX_DATA, 8'ha5);
        idle(300);
        check("holding irq", {7'h00, txIrq}, 8'h01);
        wait_tx(8'ha5);
        wb(1'b1, REG_TXRX_CONTROL, 8'h08);
        wb(1'b1, REG_TX_DATA, 8'h3c);
        idle(1500);
        check("tx halted", 8'(i_remote_serial_peer.gotCount), 8'(sent));
        wb(1'b1, REG_TXRX_CONTROL, 8'h00);
        wait_tx(8'h3c);
        ctsLine_n <= 1'b1;
        wb(1'b1, REG_ENHANCED_FEAT, 8'h90);
        wb(1'b1, REG_TX_DATA, 8'hc3);
        idle(1500);
        check("cts stall", 8'(i_remote_serial_peer.gotCount), 8'(sent));
        ctsLine_n <= 1'b0;
        wait_tx(8'hc3);
        dsrLine_n <= 1'b1;
        wb(1'b1, REG_MODEM_CONTROL, 8'h04);
        wb(1'b1, REG_TX_DATA, 8'h5a);
        idle(1500);
        check("dsr stall", 8'(i_remote_serial_peer.gotCount), 8'(sent));
        dsrLine_n <= 1'b0;
        wait_tx(8'h5a);
        wb(1'b1, REG_MODEM_CONTROL, 8'h00);
        wb(1'b1, REG_ENHANCED_FEAT, 8'h10);
        wb(1'b1, REG_FEATURE_CTRL, 8'h20);
        wb(1'b1, REG_TXRX_CONTROL, 8'h20);
        wb(1'b1, REG_TX_DATA, 8'h81);
        idle(300);
        check("dir high", {7'h00, rtsLine_n}, 8'h01);
        check("shift irq", {7'h00, txIrq}, 8'h00);
        wait_tx(8'h81);
        idle(150);
        check("turn delay", {7'h00, rtsLine_n}, 8'h01);
        idle(200);
        check("dir low", {7'h00, rtsLine_n}, 8'h00);
        check("shift empty irq", {7'h00, txIrq}, 8'h01);
        wb(1'b1, REG_TXRX_CONTROL, 8'h00);
        wb(1'b1, REG_FEATURE_CTRL, 8'h10);
        rdchk("ir polarity", REG_FEATURE_CTRL, 8'h10);
        wb(1'b1, REG_FEATURE_CTRL, 8'h00);
        // Inverted idle line looks like a start bit
        idle(1100);
        rdchk("ir idle as start", REG_RX_DATA, 8'hff);
        rx(8'h96);
        rdchk("rx count", REG_RX_LEVEL, 8'h01);
        rdchk("rx data", REG_RX_DATA, 8'h96);
        wb(1'b1, REG_TXRX_CONTROL, 8'h04);
        rx(8'h11);
        rx(8'h22);
        rdchk("rx one more", REG_RX_LEVEL, 8'h01);
        rdchk("rx while off", REG_RX_DATA, 8'h11);
        wb(1'b1, REG_TXRX_CONTROL, 8'h00);
        rx(8'h33);
        rdchk("rx resumed", REG_RX_DATA, 8'h33);
        wb(1'b1, REG_STOP_CHAR_2, 8'h13);
        wb(1'b1, REG_ENHANCED_FEAT, 8'h30);
        rx(8'h14);
        check("no special", {7'h00, special}, 8'h00);
        rx(8'h13);
        check("special", {7'h00, special}, 8'h01);
        rdchk("stored", REG_RX_LEVEL, 8'h02);
        wb(1'b0, REG_RX_DATA, ZERO_BYTE);
        rdchk("match data", REG_RX_DATA, 8'h13);
        wb(1'b0, REG_STATUS, ZERO_BYTE);
        wb(1'b1, REG_ENHANCED_FEAT, 8'h31);
        rx(8'h13);
        check("swallowed", {7'h00, stopSeen}, 8'h01);
        check("special too", {7'h00, special}, 8'h01);
        rdchk("not stored", REG_RX_LEVEL, ZERO_BYTE);
        // select bits cleared before any new choice
        wb(1'b1, REG_ENHANCED_FEAT, 8'h10);
        // request output asserted before automatic mode
        wb(1'b1, REG_MODEM_CONTROL, 8'h03);
        check("gp output", {7'h00, rtsLine_n}, 8'h00);
        check("gp dtr", {7'h00, dtrLine_n}, 8'h00);
        wb(1'b1, REG_ENHANCED_FEAT, 8'h50);
        for (int i = 0; i < UPPER_TRIGGER; i++) rx(8'(i));
        check("trigger", {7'h00, rxTrig}, 8'h01);
        check("rts off", {7'h00, rtsLine_n}, 8'h01);
        repeat (UPPER_TRIGGER - LOWER_TRIGGER) wb(1'b0, REG_RX_DATA, ZERO_BYTE);
        check("rts held", {7'h00, rtsLine_n}, 8'h01);
        wb(1'b0, REG_RX_DATA, ZERO_BYTE);
        // Hysteresis flop follows the count one edge later
        idle(1);
        check("rts on", {7'h00, rtsLine_n}, 8'h00);
        report_and_stop();
    end
endmodule : uart_enhanced_feature_control_tb
`default_nettype wire
